// ### common/power_mode_map.vh
// Constants for the low-power mode controller.
`ifndef POWER_MODE_MAP_VH
`define POWER_MODE_MAP_VH
`define REF_FREQ_MIN_KHZ      16'd6000
`define REF_FREQ_MAX_KHZ      16'd40000
`define PLL_TARGET_KHZ        16'd400
`define WDT_CLK_KHZ           16'd32
`define MODE_SEL_SUSPEND      2'h1
`define MODE_SEL_STANDBY      2'h2
`define MODE_SEL_POWERDOWN    2'h3
`define WAKE_SRC_DP           3'h0
`define WAKE_SRC_DM           3'h1
`define WAKE_SRC_SSRX         3'h2
`define WAKE_SRC_VBUS         3'h3
`define WAKE_SRC_CTS          3'h4
`define WAKE_SRC_WDT          3'h5
`define WAKE_SRC_HARD         3'h6
`define PLL_LOCK_CYCLES       8'h10
`define INT_OSC_DIV           10'h271
`endif

// ### design/low_power_mode_control.v
// Power-mode, wake, watchdog and PLL setting control for the camera bridge.
//
// Notes on behaviour
// - PLL multiplier picked from measured reference frequency.
// - Watchdog expiry can interrupt the processor.
// - Watchdog expiry wakes standby or resets core.
// - Watchdog ticks from 32 kHz, internal or external.
// - Disabled watchdog raises no interrupt, wake, reset.
// - Normal mode keeps processor clock and PLLs on.
// - Three low-power modes: suspend, standby, power-down.
// - Suspend keeps PHY in U3, stops other clocks.
// - Suspend holds every I/O at its level.
// - Registers and RAM retained through suspend.
// - Suspend ends on USB, VBUS, CTS, reset events.
// - Suspend wake resumes without program counter reset unless hard reset woke it.
// - Standby wake restarts execution from the start.
`timescale 1ns/10ps
`default_nettype none
`include "power_mode_map.vh"
module low_power_mode_control #(
  parameter integer REF_WINDOW_CYCLES = 2000,
  parameter integer WDT_WIDTH         = 16
) (
  input  wire                 core_clk,        // 20 MHz core clock.
  input  wire                 rst_n,           // Synchronous reset.
  input  wire                 hard_reset_req,  // Hard reset pin, synchronised.
  input  wire                 pll_source_clock_input, // Reference clock pin.
  input  wire                 primary_clock_input,    // Unused clock pin level.
  input  wire                 ext_32k_clk,     // External 32 kHz clock.
  input  wire                 ext_32k_sel,     // Use external 32 kHz clock.
  input  wire                 mode_req,        // Firmware mode entry strobe.
  input  wire [1:0]           mode_sel,        // Requested low-power mode.
  input  wire                 wdt_enable,      // Watchdog enable.
  input  wire                 wdt_kick,        // Restart watchdog count.
  input  wire [WDT_WIDTH-1:0] wdt_limit,       // Expiry on the tick after the count reaches this.
  input  wire                 wdt_action_reset,// Expiry resets core.
  input  wire                 wdt_irq_ack,     // Clears watchdog interrupt.
  input  wire                 usb_dp,          // D+ line level.
  input  wire                 usb_dm,          // D- line level.
  input  wire                 ssrx_resume,     // SSRX resume condition.
  input  wire                 vbus_detect,     // VBUS present.
  input  wire                 uart_cts,        // Flow-control wake level.
  input  wire                 cts_wake_pol,    // Active level of uart_cts.
  output reg  [5:0]           pll_mult,        // Selected PLL multiplier.
  output wire                 cpu_clk_en,      // Processor clock enable.
  output wire                 pll_en,          // Internal PLL enable.
  output wire                 phy_u3_hold,     // PHY kept alive in U3.
  output wire                 io_hold,         // Freeze I/O levels.
  output wire                 mem_retain,      // Keep RAM and registers.
  output wire                 core_power_off,  // Core power-down request.
  output reg                  cpu_pc_reset,    // Restart processor from start.
  output reg                  wdt_irq,         // Watchdog interrupt.
  output reg  [2:0]           wake_source,     // Last wake cause.
  output wire [2:0]           power_state      // 0 normal,1 sus,2 stby,3 off,4 wake.
);
  // ============================================================
  // Input synchronisers.
  // ============================================================
  localparam integer NSYNC = 8;
  wire [NSYNC-1:0] raw_in = {hard_reset_req, pll_source_clock_input,
    ext_32k_clk, usb_dp, usb_dm, ssrx_resume, vbus_detect, uart_cts};
  reg  [NSYNC-1:0] s1_reg, s2_reg, s3_reg, stable_reg;
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : sync
      always @(posedge core_clk) begin
        if (!rst_n) begin
          s1_reg[g]     <= 1'b0;
          s2_reg[g]     <= 1'b0;
          s3_reg[g]     <= 1'b0;
          stable_reg[g] <= 1'b0;
        end else begin
          s1_reg[g] <= raw_in[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          if (s2_reg[g] == s3_reg[g]) begin
            stable_reg[g] <= s3_reg[g];
          end
        end
      end
    end
  endgenerate
  wire hard_s = stable_reg[7];
  wire x32_s  = stable_reg[5];
  wire dp_s   = stable_reg[4];
  wire dm_s   = stable_reg[3];
  wire ssrx_s = stable_reg[2];
  wire vbus_s = stable_reg[1];
  wire cts_s  = stable_reg[0];
  reg  x32_d_reg, dp_d_reg, dm_d_reg;
  always @(posedge core_clk) begin
    x32_d_reg <= x32_s;
    dp_d_reg  <= dp_s;
    dm_d_reg  <= dm_s;
  end

  // ============================================================
  // Reference frequency measurement and multiplier choice.
  // ============================================================
  reg [15:0] win_cnt_reg;
  reg [15:0] edge_cnt_reg;
  // The reference clock is counted from the second and third stages: a
  // clock this fast never stays put long enough for the agreement filter.
  wire ref_rise = s2_reg[6] & ~s3_reg[6];
  always @(posedge core_clk) begin
    if (!rst_n) begin
      win_cnt_reg  <= 16'h0000;
      edge_cnt_reg <= 16'h0000;
      pll_mult     <= 6'h01;
    end else if (win_cnt_reg == REF_WINDOW_CYCLES[15:0] - 16'h0001) begin
      // Window is 100 us: edge count times 10 gives kHz.
      win_cnt_reg  <= 16'h0000;
      edge_cnt_reg <= 16'h0000;
      if (edge_cnt_reg * 16'd10 >= `REF_FREQ_MIN_KHZ &&
          edge_cnt_reg * 16'd10 <= `REF_FREQ_MAX_KHZ) begin
        pll_mult <= mult_for(edge_cnt_reg);
      end
    end else begin
      win_cnt_reg  <= win_cnt_reg + 16'h0001;
      edge_cnt_reg <= edge_cnt_reg + {15'h0000, ref_rise};
    end
  end
  function [5:0] mult_for;
    input [15:0] edges;
    reg   [15:0] q;
    begin
      q = (`PLL_TARGET_KHZ * 16'd100) / (edges * 16'd10);
      mult_for = (q > 16'd63) ? 6'h3f : (q == 16'h0000 ? 6'h01 : q[5:0]);
    end
  endfunction

  // ============================================================
  // Watchdog on the 32 kHz tick.
  // ============================================================
  reg [9:0] osc_div_reg;
  wire int_tick = (osc_div_reg == `INT_OSC_DIV - 10'h001);
  always @(posedge core_clk) begin
    if (!rst_n || int_tick) begin
      osc_div_reg <= 10'h000;
    end else begin
      osc_div_reg <= osc_div_reg + 10'h001;
    end
  end
  wire wdt_tick = ext_32k_sel ? (x32_s & ~x32_d_reg) : int_tick;
  reg  [WDT_WIDTH-1:0] wdt_cnt_reg;
  wire wdt_expire = wdt_enable && wdt_tick && (wdt_cnt_reg >= wdt_limit);
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wdt_cnt_reg <= {WDT_WIDTH{1'b0}};
      wdt_irq     <= 1'b0;
    end else begin
      if (!wdt_enable || wdt_kick || wdt_expire) begin
        wdt_cnt_reg <= {WDT_WIDTH{1'b0}};
      end else if (wdt_tick) begin
        wdt_cnt_reg <= wdt_cnt_reg + {{(WDT_WIDTH-1){1'b0}}, 1'b1};
      end
      if (wdt_expire && !wdt_action_reset) begin
        wdt_irq <= 1'b1;
      end else if (wdt_irq_ack || !wdt_enable) begin
        wdt_irq <= 1'b0;
      end
    end
  end

  // ============================================================
  // Power mode state machine.
  // ============================================================
  localparam [4:0] ST_NORMAL  = 5'h01;
  localparam [4:0] ST_SUSPEND = 5'h02;
  localparam [4:0] ST_STANDBY = 5'h04;
  localparam [4:0] ST_OFF     = 5'h08;
  localparam [4:0] ST_WAKE    = 5'h10;
  reg [4:0] state_reg, state_next;
  reg [7:0] lock_cnt_reg;
  reg       restart_reg;
  wire usb_wake = (dp_s ^ dp_d_reg) | (dm_s ^ dm_d_reg) | ssrx_s;
  wire cts_wake = (cts_s == cts_wake_pol);
  wire any_wake = usb_wake | vbus_s | cts_wake | hard_s;
  wire in_wake  = (state_reg == ST_WAKE);
  wire locked   = (lock_cnt_reg == `PLL_LOCK_CYCLES);
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_NORMAL: begin
        if (mode_req) begin
          case (mode_sel)
            `MODE_SEL_SUSPEND:   state_next = ST_SUSPEND;
            `MODE_SEL_STANDBY:   state_next = ST_STANDBY;
            `MODE_SEL_POWERDOWN: state_next = ST_OFF;
            default:             state_next = ST_NORMAL;
          endcase
        end
      end
      ST_SUSPEND: if (any_wake) state_next = ST_WAKE;
      ST_STANDBY: if (any_wake || wdt_expire) state_next = ST_WAKE;
      ST_OFF:     if (hard_s) state_next = ST_WAKE;
      ST_WAKE:    if (locked) state_next = ST_NORMAL;
      default:    state_next = ST_NORMAL;
    endcase
  end
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg    <= ST_NORMAL;
      lock_cnt_reg <= 8'h00;
      restart_reg  <= 1'b0;
      wake_source  <= 3'h0;
      cpu_pc_reset <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (in_wake && !locked) begin
        lock_cnt_reg <= lock_cnt_reg + 8'h01;
      end else if (!in_wake) begin
        lock_cnt_reg <= 8'h00;
      end
      if (state_reg != ST_WAKE && state_next == ST_WAKE) begin
        // Suspend resumes in place unless hard reset woke it.
        restart_reg <= hard_s || state_reg != ST_SUSPEND;
        if (hard_s) begin
          wake_source <= `WAKE_SRC_HARD;
        end else if (state_reg == ST_STANDBY && wdt_expire) begin
          wake_source <= `WAKE_SRC_WDT;
        end else if (dp_s ^ dp_d_reg) begin
          wake_source <= `WAKE_SRC_DP;
        end else if (dm_s ^ dm_d_reg) begin
          wake_source <= `WAKE_SRC_DM;
        end else if (ssrx_s) begin
          wake_source <= `WAKE_SRC_SSRX;
        end else if (vbus_s) begin
          wake_source <= `WAKE_SRC_VBUS;
        end else begin
          wake_source <= `WAKE_SRC_CTS;
        end
      end
      cpu_pc_reset <= (in_wake && restart_reg) ||
                      (state_reg == ST_NORMAL && wdt_expire &&
                       wdt_action_reset);
    end
  end
  // Processor stays stopped through the PLL relock of the wake state.
  assign cpu_clk_en     = (state_reg == ST_NORMAL);
  assign pll_en         = (state_reg == ST_NORMAL) || in_wake;
  assign phy_u3_hold    = (state_reg == ST_SUSPEND);
  assign io_hold        = (state_reg == ST_SUSPEND) ||
                          (state_reg == ST_STANDBY);
  assign mem_retain     = (state_reg != ST_OFF);
  assign core_power_off = (state_reg == ST_OFF);
  assign power_state    = state_reg[0] ? 3'h0 : state_reg[1] ? 3'h1 :
                          state_reg[2] ? 3'h2 : state_reg[3] ? 3'h3 : 3'h4;
endmodule
`default_nettype wire

// ### verif/low_power_mode_sva.sv
// Port assertions for the low-power mode controller.
`timescale 1ns/10ps
`default_nettype none
module low_power_mode_sva (
  input wire logic       core_clk,       // Clock.
  input wire logic       rst_n,          // Reset.
  input wire logic       hard_reset_req, // Hard reset.
  input wire logic       mode_req,       // Entry strobe.
  input wire logic [1:0] mode_sel,       // Mode.
  input wire logic       vbus_detect,    // Wake pin.
  input wire logic       wdt_enable,     // Watchdog on.
  input wire logic       wdt_irq,        // Watchdog irq.
  input wire logic       cpu_clk_en,     // CPU clock.
  input wire logic       pll_en,         // PLL on.
  input wire logic       phy_u3_hold,    // PHY in U3.
  input wire logic       io_hold,        // I/O frozen.
  input wire logic       mem_retain,     // Retention.
  input wire logic       core_power_off, // Core off.
  input wire logic [2:0] power_state     // State.
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Mode entry and wake
  sequence s_enter;
    power_state == 3'h0 && mode_req && mode_sel == 2'h1 && !hard_reset_req;
  endsequence
  sequence s_wake;
    $rose(power_state == 3'h4);
  endsequence
  property p_normal;
    power_state == 3'h0 |-> cpu_clk_en && pll_en;
  endproperty
  a_normal: assert property (p_normal)
    else $error("normal mode without clocks");
  property p_enter;
    s_enter |=> power_state == 3'h1 && phy_u3_hold && io_hold;
  endproperty
  a_enter: assert property (p_enter)
    else $error("suspend not entered");
  property p_suspend;
    power_state == 3'h1 |-> !cpu_clk_en && !pll_en && io_hold && mem_retain;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("suspend outputs wrong");
  property p_fw_only;
    power_state == 3'h1 && $past(power_state) == 3'h0 |-> $past(mode_req);
  endproperty
  a_fw_only: assert property (p_fw_only)
    else $error("suspend without request");
  property p_vbus;
    power_state == 3'h1 && vbus_detect |-> ##[1:6] power_state == 3'h4;
  endproperty
  a_vbus: assert property (p_vbus)
    else $error("no wake on vbus");
  property p_wake_len;
    s_wake |-> pll_en ##[15:19] power_state == 3'h0;
  endproperty
  a_wake_len: assert property (p_wake_len)
    else $error("wake did not restore normal");
  property p_wdt_off;
    !wdt_enable && !$past(wdt_enable) |-> !wdt_irq;
  endproperty
  a_wdt_off: assert property (p_wdt_off)
    else $error("irq from disabled watchdog");
  property p_off;
    power_state == 3'h3 |-> core_power_off && !cpu_clk_en;
  endproperty
  a_off: assert property (p_off)
    else $error("power-down outputs wrong");
endmodule
bind low_power_mode_control low_power_mode_sva i_low_power_mode_sva (
  .core_clk(core_clk), .rst_n(rst_n), .hard_reset_req(hard_reset_req),
  .mode_req(mode_req), .mode_sel(mode_sel), .vbus_detect(vbus_detect),
  .wdt_enable(wdt_enable), .wdt_irq(wdt_irq), .cpu_clk_en(cpu_clk_en),
  .pll_en(pll_en), .phy_u3_hold(phy_u3_hold), .io_hold(io_hold),
  .mem_retain(mem_retain), .core_power_off(core_power_off),
  .power_state(power_state));
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the low-power mode controller.
`timescale 1ns/10ps
`default_nettype none
`include "power_mode_map.vh"
module testbench;
  logic core_clk, rst_n, hard_reset_req, ref_clk, ext_32k_clk, ext_32k_sel;
  logic mode_req, wdt_enable, wdt_kick, wdt_action_reset, wdt_irq_ack;
  logic usb_dp, usb_dm, ssrx_resume, vbus_detect, uart_cts, cts_wake_pol;
  logic [1:0] mode_sel;
  logic [15:0] wdt_limit;
  logic pc_seen;
  wire [5:0] pll_mult;
  wire cpu_clk_en, pll_en, phy_u3_hold, io_hold, mem_retain, core_power_off;
  wire cpu_pc_reset, wdt_irq;
  wire [2:0] wake_source, power_state;
  integer n_mismatch = 0, comparisons = 0, s;
  low_power_mode_control i_low_power_mode_control (
    .core_clk(core_clk), .rst_n(rst_n), .hard_reset_req(hard_reset_req),
    .pll_source_clock_input(ref_clk), .primary_clock_input(1'b0),
    .ext_32k_clk(ext_32k_clk), .ext_32k_sel(ext_32k_sel), .mode_req(mode_req),
    .mode_sel(mode_sel), .wdt_enable(wdt_enable), .wdt_kick(wdt_kick),
    .wdt_limit(wdt_limit), .wdt_action_reset(wdt_action_reset),
    .wdt_irq_ack(wdt_irq_ack), .usb_dp(usb_dp), .usb_dm(usb_dm),
    .ssrx_resume(ssrx_resume), .vbus_detect(vbus_detect), .uart_cts(uart_cts),
    .cts_wake_pol(cts_wake_pol), .pll_mult(pll_mult), .cpu_clk_en(cpu_clk_en),
    .pll_en(pll_en), .phy_u3_hold(phy_u3_hold), .io_hold(io_hold),
    .mem_retain(mem_retain), .core_power_off(core_power_off),
    .cpu_pc_reset(cpu_pc_reset), .wdt_irq(wdt_irq), .wake_source(wake_source),
    .power_state(power_state));
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wait_state(input logic [2:0] st);
    integer i;
    for (i = 0; i < 3000 && power_state !== st; i = i + 1) begin
      @(posedge core_clk);
      #1;
      pc_seen = pc_seen | (cpu_pc_reset === 1'b1);
    end
    if (power_state !== st) begin
      n_mismatch = n_mismatch + 1;
      results();
    end
  endtask
  task automatic enter(input logic [1:0] m);
    @(posedge core_clk);
    mode_sel <= m;
    mode_req <= 1'b1;
    @(posedge core_clk);
    mode_req <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_suspend(input integer src);
    enter(2'h1);
    check({3'h0, phy_u3_hold, io_hold, cpu_clk_en, pll_en, mem_retain},
          8'h19);
    pc_seen = 1'b0;
    @(posedge core_clk);
    case (src)
      0: usb_dp <= ~usb_dp;
      1: usb_dm <= ~usb_dm;
      2: ssrx_resume <= 1'b1;
      3: vbus_detect <= 1'b1;
      4: uart_cts <= cts_wake_pol;
      default: hard_reset_req <= 1'b1;
    endcase
    wait_state(3'h4);
    check(8'(wake_source), (src == 5) ? 8'(`WAKE_SRC_HARD) : 8'(src));
    check(8'(pll_en), 8'h1);
    @(posedge core_clk);
    {ssrx_resume, vbus_detect, uart_cts, hard_reset_req} <= 4'h0;
    wait_state(3'h0);
    check(8'(pc_seen), 8'(src == 5));
  endtask
  task automatic t_watchdog;
    enter(2'h2);
    check(8'(power_state), 8'h2);
    pc_seen = 1'b0;
    @(posedge core_clk);
    wdt_enable <= 1'b1;
    wait_state(3'h4);
    check(8'(wake_source), 8'(`WAKE_SRC_WDT));
    wait_state(3'h0);
    check(8'(pc_seen), 8'h1);
    for (s = 0; s < 1400 && wdt_irq !== 1'b1; s = s + 1)
      @(posedge core_clk);
    check(8'(wdt_irq), 8'h1);
    @(posedge core_clk);
    wdt_irq_ack <= 1'b1;
    wdt_action_reset <= 1'b1;
    @(posedge core_clk);
    wdt_irq_ack <= 1'b0;
    pc_seen = 1'b0;
    repeat (1400) @(posedge core_clk) pc_seen = pc_seen | cpu_pc_reset;
    check(8'(pc_seen), 8'h1);
    wdt_enable <= 1'b0;
    wdt_action_reset <= 1'b0;
    pc_seen = 1'b0;
    repeat (1400) @(posedge core_clk)
      pc_seen = pc_seen | wdt_irq | cpu_pc_reset;
    check(8'(pc_seen), 8'h0);
    enter(2'h2);
    repeat (1400) @(posedge core_clk);
    #1;
    check(8'(power_state), 8'h2);
    @(posedge core_clk);
    vbus_detect <= 1'b1;
    wait_state(3'h4);
    @(posedge core_clk);
    vbus_detect <= 1'b0;
    wait_state(3'h0);
  endtask
  task automatic t_ext32k;
    integer i;
    @(posedge core_clk);
    ext_32k_sel <= 1'b1;
    wdt_enable <= 1'b1;
    pc_seen = 1'b0;
    repeat (1400) @(posedge core_clk) pc_seen = pc_seen | wdt_irq;
    check(8'(pc_seen), 8'h0);
    for (i = 0; i < 5; i = i + 1) begin
      repeat (8) @(posedge core_clk);
      ext_32k_clk <= ~ext_32k_clk;
      wdt_kick <= (i == 1);
    end
    #1;
    check(8'(wdt_irq), 8'h0);
    repeat (8) @(posedge core_clk);
    #1;
    check(8'(wdt_irq), 8'h1);
    @(posedge core_clk);
    wdt_irq_ack <= 1'b1;
    wdt_enable <= 1'b0;
    ext_32k_sel <= 1'b0;
    @(posedge core_clk);
    wdt_irq_ack <= 1'b0;
  endtask
  task automatic t_off;
    enter(2'h0);
    check(8'(power_state), 8'h0);
    enter(2'h3);
    check(8'(core_power_off), 8'h1);
    @(posedge core_clk);
    vbus_detect <= 1'b1;
    repeat (10) @(posedge core_clk);
    vbus_detect <= 1'b0;
    hard_reset_req <= 1'b1;
    check(8'(power_state), 8'h3);
    wait_state(3'h4);
    check(8'(wake_source), 8'(`WAKE_SRC_HARD));
    @(posedge core_clk);
    hard_reset_req <= 1'b0;
    wait_state(3'h0);
  endtask
  // ==========================================================
  // Clocks and main sequence
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) ref_clk <= ~ref_clk;
  initial begin
    {rst_n, hard_reset_req, ref_clk, ext_32k_clk, ext_32k_sel} = 5'h0;
    {mode_req, wdt_enable, wdt_kick, wdt_action_reset, wdt_irq_ack} = 5'h0;
    {usb_dp, usb_dm, ssrx_resume, vbus_detect, uart_cts} = 5'h0;
    cts_wake_pol = 1'b1;
    mode_sel = 2'h0;
    wdt_limit = 16'h1;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    check({2'h0, cpu_clk_en, pll_en, mem_retain, phy_u3_hold, io_hold,
           core_power_off}, 8'h38);
    for (s = 0; s < 6; s = s + 1)
      t_suspend(s);
    t_watchdog();
    t_ext32k();
    t_off();
    repeat (4100) @(posedge core_clk);
    check(8'(pll_mult), 8'h4);
    results();
  end
endmodule
`default_nettype wire
